//--- pkg/osc_trim_pkg.sv
package osc_trim_pkg;

   // Bus geometry
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int IDX_W = 6;
   localparam int TRIM_W = 16;
   localparam int TC_W = 5;
   localparam int FREQ_W = 10;

   // Register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] TRIM_HIGH_IDX = 6'h18;
   localparam logic [IDX_W-1:0] TRIM_LOW_IDX = 6'h19;
   localparam logic [IDX_W-1:0] CLOCK_CONFIG_LOCK_IDX = 6'h1B;
   localparam logic [IDX_W-1:0] CLK_STAT_IDX = 6'h20;

   // Trim pair field layout
   localparam int TC_MSB = 15;
   localparam int TC_LSB = 11;
   localparam int TC_SIGN_BIT = 15;
   localparam int FREQ_MSB = 9;
   localparam int FREQ_LSB = 0;
   localparam logic [TRIM_W-1:0] TRIM_RW_MASK = 16'hFBFF;

   // Clock status register bits
   localparam int STAT_PLL_CLOCK_SELECT_BIT = 0;
   localparam int STAT_LOCK_BIT = 1;
   localparam int STAT_OSCUP_BIT = 2;

   // Protection key
   localparam logic [7:0] CLOCK_CONFIG_LOCK_KEY = 8'h26;

   // Reset values
   localparam logic [TRIM_W-1:0] TRIM_RST = 16'h0000;
   localparam logic LOCK_RST = 1'b0;
   localparam logic PLL_CLOCK_SELECT_RST = 1'b0;
   localparam logic FLAG_RST = 1'b0;

endpackage : osc_trim_pkg

//--- core/flash_trim_loader.sv
`timescale 1ns/10ps
`default_nettype none

module flash_trim_loader (
   input wire logic clk,
   input wire logic srst,
   output logic flash_rd_req,
   input wire logic flash_rd_ack,
   input wire logic [osc_trim_pkg::TRIM_W-1:0] flash_rd_data,
   output logic load_valid,
   output logic [osc_trim_pkg::TRIM_W-1:0] load_data,
   output logic load_done
);
   import osc_trim_pkg::*;

   typedef enum logic {LD_FETCH, LD_DONE} ld_state_t;

   ld_state_t state_q;
   wire got_word = flash_rd_req & flash_rd_ack;

   // One fetch after every reset release
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= LD_FETCH;
         flash_rd_req <= 1'b0;
         load_valid <= 1'b0;
         load_data <= TRIM_RST;
         load_done <= 1'b0;
      end else begin
         load_valid <= 1'b0;
         unique case (state_q)
            LD_FETCH: begin
               flash_rd_req <= ~got_word;
               if (got_word) begin
                  load_valid <= 1'b1;
                  load_data <= flash_rd_data;
                  load_done <= 1'b1;
                  state_q <= LD_DONE;
               end
            end
            LD_DONE: begin
               flash_rd_req <= 1'b0;
            end
         endcase
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   AST_REQ_HOLD: assert property (flash_rd_req && !flash_rd_ack |=> flash_rd_req)
      else $error("Flash request dropped before answer");
   AST_ONE_LOAD: assert property (load_done |=> !flash_rd_req && !load_valid)
      else $error("Second flash load after completion");

endmodule : flash_trim_loader

`default_nettype wire

//--- core/internal_osc_trim_regs.sv
// Function
// - Reset release fetches the factory trim word from flash into both trim registers.
// - Trim registers read at any time and take writes only while the config lock is clear.
// - An accepted trim write with the PLL clock selected clears the lock and oscillator-up flags.
// - Trim pair bits 15 to 11 form the temperature coefficient trim field.
// - Trim pair bits 9 to 0 form the frequency trim field.
// - Coefficient codes 00000 and 10000 switch the compensation off.
// - The coefficient top bit picks the sign and the low four bits the growing magnitude.
// - Writing 0x26 to the protection register clears the lock and any other write sets it.
`timescale 1ns/10ps
`default_nettype none

module internal_osc_trim_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [osc_trim_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [osc_trim_pkg::DAT_W-1:0] wb_dat_i,
   output logic [osc_trim_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic flash_rd_req,
   input wire logic flash_rd_ack,
   input wire logic [osc_trim_pkg::TRIM_W-1:0] flash_rd_data,
   input wire logic pll_lock_set,
   input wire logic osc_up_set,
   output logic [osc_trim_pkg::TC_W-1:0] temp_coeff_trim,
   output logic [osc_trim_pkg::FREQ_W-1:0] osc_freq_trim,
   output logic tc_comp_enable,
   output logic tc_positive,
   output logic [3:0] tc_magnitude,
   output logic clock_config_lock,
   output logic pll_clock_select,
   output logic pll_lock_flag,
   output logic osc_up_flag,
   output logic trim_loaded
);
   import osc_trim_pkg::*;

   // Index compare for register decode
   function automatic logic idx_hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] reg_idx);
      idx_hit = (idx == reg_idx);
   endfunction : idx_hit

   // Coefficient magnitude, zero means compensation off
   function automatic logic [3:0] tc_mag(input logic [TRIM_W-1:0] t);
      tc_mag = t[TC_MSB-1:TC_LSB];
   endfunction : tc_mag

   logic [TRIM_W-1:0] trim_q;
   logic [TRIM_W-1:0] trim_d;
   logic lock_d;
   logic pll_sel_d;
   logic pll_lock_d;
   logic osc_up_d;
   logic [DAT_W-1:0] dat_d;
   logic load_valid;
   logic [TRIM_W-1:0] load_data;
   logic load_done;

   flash_trim_loader flash_trim_loader_i (
      .clk(clk),
      .srst(srst),
      .flash_rd_req(flash_rd_req),
      .flash_rd_ack(flash_rd_ack),
      .flash_rd_data(flash_rd_data),
      .load_valid(load_valid),
      .load_data(load_data),
      .load_done(load_done)
   );

   // Bus decode
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i & wb_sel_i[0];
   wire rd = req & ~wb_we_i;
   wire [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
   wire [7:0] wr_byte = wb_dat_i[7:0];
   wire hit_high = idx_hit(idx, TRIM_HIGH_IDX);
   wire hit_low = idx_hit(idx, TRIM_LOW_IDX);
   wire hit_clock_config_lock = idx_hit(idx, CLOCK_CONFIG_LOCK_IDX);
   wire hit_stat = idx_hit(idx, CLK_STAT_IDX);
   wire wr_high = wr & hit_high;
   wire wr_low = wr & hit_low;
   wire wr_clock_config_lock = wr & hit_clock_config_lock;
   wire wr_stat = wr & hit_stat & ~clock_config_lock;

   // Trim write acceptance, flash load wins
   wire trim_wr_ok = (wr_high | wr_low) & ~clock_config_lock & ~load_valid;
   wire [7:0] hi_new = wr_high ? wr_byte : trim_q[15:8];
   wire [7:0] lo_new = wr_low ? wr_byte : trim_q[7:0];
   wire flag_clr = trim_wr_ok & pll_clock_select;

   assign trim_d = load_valid ? (load_data & TRIM_RW_MASK) :
                   trim_wr_ok ? ({hi_new, lo_new} & TRIM_RW_MASK) : trim_q;
   assign lock_d = wr_clock_config_lock ? (wr_byte != CLOCK_CONFIG_LOCK_KEY) : clock_config_lock;
   assign pll_sel_d = wr_stat ? wr_byte[STAT_PLL_CLOCK_SELECT_BIT] : pll_clock_select;
   assign pll_lock_d = pll_lock_set | (pll_lock_flag & ~flag_clr);
   assign osc_up_d = osc_up_set | (osc_up_flag & ~flag_clr);

   // Read mux, unmapped reads zero
   wire [7:0] stat_byte = {5'h00, osc_up_flag, pll_lock_flag, pll_clock_select};
   wire [7:0] rd_byte = hit_high ? trim_q[15:8] :
                        hit_low ? trim_q[7:0] :
                        hit_clock_config_lock ? {7'h00, clock_config_lock} :
                        hit_stat ? stat_byte : 8'h00;
   assign dat_d = rd ? {{(DAT_W-8){1'b0}}, rd_byte} : wb_dat_o;

   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= dat_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         trim_q <= TRIM_RST;
         clock_config_lock <= LOCK_RST;
         pll_clock_select <= PLL_CLOCK_SELECT_RST;
         pll_lock_flag <= FLAG_RST;
         osc_up_flag <= FLAG_RST;
      end else begin
         trim_q <= trim_d;
         clock_config_lock <= lock_d;
         pll_clock_select <= pll_sel_d;
         pll_lock_flag <= pll_lock_d;
         osc_up_flag <= osc_up_d;
      end
   end

   // Oscillator-facing fields, registered from the next trim value
   always_ff @(posedge clk) begin
      if (srst) begin
         temp_coeff_trim <= TRIM_RST[TC_MSB:TC_LSB];
         osc_freq_trim <= TRIM_RST[FREQ_MSB:FREQ_LSB];
         tc_comp_enable <= 1'b0;
         tc_positive <= 1'b0;
         tc_magnitude <= 4'h0;
         trim_loaded <= 1'b0;
      end else begin
         temp_coeff_trim <= trim_d[TC_MSB:TC_LSB];
         osc_freq_trim <= trim_d[FREQ_MSB:FREQ_LSB];
         tc_comp_enable <= (tc_mag(trim_d) != 4'h0);
         tc_positive <= trim_d[TC_SIGN_BIT];
         tc_magnitude <= tc_mag(trim_d);
         trim_loaded <= load_done;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   AST_LOAD_APPLY: assert property (load_valid |=> trim_q == ($past(load_data) & TRIM_RW_MASK))
      else $error("Flash trim word not applied");

   AST_LOAD_OUTPUTS: assert property (load_valid ##1 1'b1 |=> osc_freq_trim == $past(trim_q[FREQ_MSB:FREQ_LSB]))
      else $error("Loaded frequency trim not on output");

   AST_WRITE_BLOCKED: assert property ((wr_high || wr_low) && clock_config_lock && !load_valid
                                       |=> trim_q == $past(trim_q))
      else $error("Trim changed while locked");

   AST_WRITE_HIGH: assert property (wr_high && !clock_config_lock && !load_valid
                                    |=> trim_q[15:8] == ($past(wr_byte) & TRIM_RW_MASK[15:8]))
      else $error("Unlocked high trim write lost");

   AST_WRITE_LOW: assert property (wr_low && !clock_config_lock && !load_valid
                                   |=> trim_q[7:0] == $past(wr_byte) && trim_q[15:8] == $past(trim_q[15:8]))
      else $error("Unlocked low trim write wrong");

   AST_READ_TRIM: assert property (rd && hit_high |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(trim_q[15:8])})
      else $error("High trim read returned wrong data");

   AST_FLAG_CLEAR: assert property (flag_clr && !pll_lock_set && !osc_up_set |=> !pll_lock_flag && !osc_up_flag)
      else $error("Flags not cleared by trim write");

   AST_FLAG_KEEP: assert property (pll_lock_flag && !(trim_wr_ok && pll_clock_select) |=> pll_lock_flag)
      else $error("Lock flag cleared without cause");

   AST_SET_WINS: assert property (flag_clr && osc_up_set |=> osc_up_flag)
      else $error("Set lost against clear");

   AST_TC_FIELD: assert property (##1 temp_coeff_trim == trim_q[TC_MSB:TC_LSB])
      else $error("Coefficient field mismatch");

   AST_FREQ_FIELD: assert property (##1 osc_freq_trim == trim_q[FREQ_MSB:FREQ_LSB])
      else $error("Frequency field mismatch");

   AST_TC_OFF: assert property (temp_coeff_trim[3:0] == 4'h0 |-> !tc_comp_enable)
      else $error("Compensation on for nominal code");

   AST_TC_SIGN: assert property (tc_comp_enable |-> tc_positive == temp_coeff_trim[4]
                                 && tc_magnitude == temp_coeff_trim[3:0])
      else $error("Coefficient sign or magnitude wrong");

   AST_CLOCK_CONFIG_LOCK_KEY: assert property (wr_clock_config_lock && wr_byte == CLOCK_CONFIG_LOCK_KEY |=> !clock_config_lock)
      else $error("Key write did not unlock");

   AST_CLOCK_CONFIG_LOCK_SET: assert property (wr_clock_config_lock && wr_byte != CLOCK_CONFIG_LOCK_KEY |=> clock_config_lock)
      else $error("Other write did not lock");

   AST_BIT10_ZERO: assert property (trim_q[10] == 1'b0)
      else $error("Trim bit 10 not zero");

   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle");

   AST_ACK_AFTER_REQ: assert property (req |=> wb_ack_o)
      else $error("Accepted request not acknowledged");

   AST_NO_SPURIOUS_ACK: assert property (!req |=> !wb_ack_o)
      else $error("Ack without a request");

   AST_READ_LOW: assert property (rd && hit_low |=> wb_dat_o == {24'h00_0000, $past(trim_q[7:0])})
      else $error("Low trim read returned wrong data");

   AST_READ_CLOCK_CONFIG_LOCK: assert property (rd && hit_clock_config_lock |=> wb_dat_o == {31'h0000_0000, $past(clock_config_lock)})
      else $error("Protection read returned wrong data");

   AST_READ_STAT: assert property (rd && hit_stat
                                   |=> wb_dat_o[7:0] == {5'h00, $past(osc_up_flag), $past(pll_lock_flag),
                                                         $past(pll_clock_select)})
      else $error("Status read returned wrong data");

   AST_READ_UNMAPPED: assert property (rd && !hit_high && !hit_low && !hit_clock_config_lock && !hit_stat
                                       |=> wb_dat_o == 32'h0000_0000)
      else $error("Unmapped read not zero");

   AST_DAT_HOLD: assert property (!rd |=> wb_dat_o == $past(wb_dat_o))
      else $error("Read data changed without a read");

   AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h00_0000)
      else $error("Read data upper bits not zero");

   AST_OSC_KEEP: assert property (osc_up_flag && !flag_clr |=> osc_up_flag)
      else $error("Oscillator-up flag cleared without cause");

   AST_LOCK_FLAG_SET: assert property (pll_lock_set |=> pll_lock_flag)
      else $error("Lock flag not set");

   AST_OSC_FLAG_SET: assert property (osc_up_set |=> osc_up_flag)
      else $error("Oscillator-up flag not set");

   AST_NO_CLR_UNSELECTED: assert property ((wr_high || wr_low) && !pll_clock_select && pll_lock_flag
                                           |=> pll_lock_flag)
      else $error("Lock flag cleared with PLL clock off");

   AST_LOCK_HOLD: assert property (!wr_clock_config_lock |=> clock_config_lock == $past(clock_config_lock))
      else $error("Lock changed without a protection write");

   AST_CLOCK_CONFIG_LOCK_SEL_IGNORED: assert property (req && wb_we_i && hit_clock_config_lock && !wb_sel_i[0]
                                          |=> clock_config_lock == $past(clock_config_lock))
      else $error("Protection write without byte select took effect");

   AST_STAT_WRITE: assert property (wr_stat |=> pll_clock_select == $past(wr_byte[STAT_PLL_CLOCK_SELECT_BIT]))
      else $error("Clock select write lost");

   AST_SEL_LOCKED: assert property (wr && hit_stat && clock_config_lock
                                    |=> pll_clock_select == $past(pll_clock_select))
      else $error("Clock select changed while locked");

   AST_TRIM_IDLE: assert property (!load_valid && !trim_wr_ok |=> trim_q == $past(trim_q))
      else $error("Trim changed without a write or load");

   AST_HIGH_KEEPS_LOW: assert property (wr_high && !clock_config_lock && !load_valid
                                        |=> trim_q[7:0] == $past(trim_q[7:0]))
      else $error("High trim write disturbed low byte");

   AST_SEL0_IGNORED: assert property (req && wb_we_i && !wb_sel_i[0] && !load_valid
                                      |=> trim_q == $past(trim_q))
      else $error("Trim write without byte select took effect");

   AST_LOADED_STICKY: assert property (trim_loaded |=> trim_loaded)
      else $error("Load done flag dropped");

   AST_LOADED_AFTER: assert property (load_valid |=> trim_loaded)
      else $error("Load done flag late");

   AST_SIGN_FIELD: assert property (tc_positive == temp_coeff_trim[4])
      else $error("Coefficient sign not from top bit");

   AST_MAG_FIELD: assert property (tc_magnitude == temp_coeff_trim[3:0])
      else $error("Coefficient magnitude not from low bits");

   AST_TC_ON: assert property (temp_coeff_trim[3:0] != 4'h0 |-> tc_comp_enable)
      else $error("Compensation off for nonzero magnitude");

   AST_TC_HIGH_WRITE: assert property (wr_high && !clock_config_lock && !load_valid
                                       |=> temp_coeff_trim == $past(wr_byte[7:3]))
      else $error("Coefficient output not from high byte");

   AST_FREQ_LOW_WRITE: assert property (wr_low && !clock_config_lock && !load_valid
                                        |=> osc_freq_trim[7:0] == $past(wr_byte))
      else $error("Frequency output not from low byte");

   AST_FREQ_HIGH_BITS: assert property (wr_high && !clock_config_lock && !load_valid
                                        |=> osc_freq_trim[9:8] == $past(wr_byte[1:0]))
      else $error("Frequency top bits not from high byte");

   COV_WRITE_OK: cover property (trim_wr_ok);
   COV_WRITE_LOCKED: cover property ((wr_high || wr_low) && clock_config_lock);
   COV_FLAG_CLR: cover property (flag_clr && pll_lock_flag);
   COV_LOAD: cover property (load_valid);
   COV_SET_WINS: cover property (flag_clr && osc_up_set);

endmodule : internal_osc_trim_regs

`default_nettype wire

//--- testbench/internal_osc_trim_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module internal_osc_trim_regs_tb;
   import osc_trim_pkg::*;

   logic clk, srst, cyc, stb, we, ack, flash_rd_req, flash_rd_ack, pll_lock_set, osc_up_set;
   logic tc_comp_enable, tc_positive, clock_config_lock, pll_clock_select, pll_lock_flag, osc_up_flag, trim_loaded;
   logic [7:0] adr;
   logic [3:0] sel, tc_magnitude;
   logic [31:0] dat_i, dat_o, rd;
   logic [15:0] flash_rd_data;
   logic [4:0] temp_coeff_trim;
   logic [9:0] osc_freq_trim;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   localparam logic [7:0] A_HI = {TRIM_HIGH_IDX, 2'b00};
   localparam logic [7:0] A_LO = {TRIM_LOW_IDX, 2'b00};
   localparam logic [7:0] A_PR = {CLOCK_CONFIG_LOCK_IDX, 2'b00};
   localparam logic [7:0] A_ST = {CLK_STAT_IDX, 2'b00};

   internal_osc_trim_regs internal_osc_trim_regs_i (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .flash_rd_req(flash_rd_req), .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data),
      .pll_lock_set(pll_lock_set), .osc_up_set(osc_up_set), .temp_coeff_trim(temp_coeff_trim),
      .osc_freq_trim(osc_freq_trim), .tc_comp_enable(tc_comp_enable), .tc_positive(tc_positive),
      .tc_magnitude(tc_magnitude), .clock_config_lock(clock_config_lock), .pll_clock_select(pll_clock_select),
      .pll_lock_flag(pll_lock_flag), .osc_up_flag(osc_up_flag), .trim_loaded(trim_loaded));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Classic single Wishbone cycle, read data kept in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      dat_i <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // Factory word with bit 10 set, coefficient 10100
   task automatic load_scenario;
      int n;
      n = 0;
      while (flash_rd_req !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      check(flash_rd_req, 32'h1);
      flash_rd_ack <= 1'b1;
      flash_rd_data <= 16'hA5F3;
      @(posedge clk);
      flash_rd_ack <= 1'b0;
      flash_rd_data <= 16'h5A0C;
      repeat (2) @(posedge clk);
      check(trim_loaded, 32'h1);
      check(temp_coeff_trim, 32'h14);
      check(osc_freq_trim, 32'h1F3);
      check({tc_comp_enable, tc_positive, tc_magnitude}, 32'h34);
      wb(1'b0, A_HI, 8'h00);
      check(rd, 32'hA1);
      wb(1'b0, A_LO, 8'h00);
      check(rd, 32'hF3);
   endtask : load_scenario

   task automatic lock_scenario;
      wb(1'b1, A_PR, 8'h00);
      check(clock_config_lock, 32'h1);
      wb(1'b1, A_HI, 8'h7F);
      wb(1'b0, A_HI, 8'h00);
      check(rd, 32'hA1);
      wb(1'b1, A_PR, 8'h26);
      check(clock_config_lock, 32'h0);
      wb(1'b1, A_HI, 8'h84);
      check({tc_comp_enable, tc_positive}, 32'h1);
      wb(1'b0, A_HI, 8'h00);
      check(rd, 32'h80);
      wb(1'b1, A_HI, 8'h00);
      check(tc_comp_enable, 32'h0);
      wb(1'b1, A_HI, 8'h08);
      check({tc_comp_enable, tc_positive, tc_magnitude}, 32'h21);
      wb(1'b1, A_HI, 8'hF8);
      check({tc_comp_enable, tc_positive, tc_magnitude}, 32'h3F);
      wb(1'b0, 8'hFC, 8'h00);
      check(rd, 32'h0);
   endtask : lock_scenario

   task automatic flag_scenario;
      @(posedge clk);
      pll_lock_set <= 1'b1;
      osc_up_set <= 1'b1;
      @(posedge clk);
      pll_lock_set <= 1'b0;
      osc_up_set <= 1'b0;
      @(posedge clk);
      wb(1'b1, A_LO, 8'h55);
      check({pll_lock_flag, osc_up_flag}, 32'h3);
      wb(1'b1, A_ST, 8'h01);
      check(pll_clock_select, 32'h1);
      wb(1'b1, A_PR, 8'h01);
      wb(1'b1, A_LO, 8'h11);
      check({pll_lock_flag, osc_up_flag}, 32'h3);
      wb(1'b1, A_PR, 8'h26);
      wb(1'b1, A_LO, 8'h22);
      check({pll_lock_flag, osc_up_flag}, 32'h0);
      wb(1'b0, A_LO, 8'h00);
      check(rd, 32'h22);
      pll_lock_set <= 1'b1;
      osc_up_set <= 1'b1;
      @(posedge clk);
      pll_lock_set <= 1'b0;
      wb(1'b1, A_HI, 8'h00);
      check({pll_lock_flag, osc_up_flag}, 32'h1);
      osc_up_set <= 1'b0;
   endtask : flag_scenario

   // Reset in mid-run, then a fresh flash fetch
   task automatic reset_scenario;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      check(trim_loaded, 32'h0);
      load_scenario();
   endtask : reset_scenario

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   initial begin
      srst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_i = 32'h0;
      flash_rd_ack = 1'b0;
      flash_rd_data = 16'h0000;
      pll_lock_set = 1'b0;
      osc_up_set = 1'b0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      load_scenario();
      lock_scenario();
      flag_scenario();
      reset_scenario();
      tally_and_finish();
   end

endmodule : internal_osc_trim_regs_tb

`default_nettype wire
